// [hw/slp_ctrl.sv]
// sleep mode controller with per-peripheral clock gating
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps
module slp_ctrl
   import slp_pkg::*;
#(
   parameter int OSC_START_CYC = SLP_OSC_START_CYC
)
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rstn,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic [3:0]       wb_sel_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // cpu side
   input  wire logic             sleep_instr,
   input  wire logic             wake_serviced,
   output logic                  cpu_halt,
   output logic                  resume_ok,
   // wake sources
   input  wire slp_wake_t        wake_src,
   // clock enables
   output slp_clken_t            clk_en,
   output logic [SLP_NPER-1:0]   per_clk_en,
   output logic [SLP_NPER-1:0]   per_io_en
);
   logic          rst_s1_r;
   logic          rst_s2_r;
   logic          rst_n;
   slp_wake_t     wake_s1_r;
   slp_wake_t     wake_s2_r;
   logic [7:0]    ctrl_r;
   logic [7:0]    wcfg_r;
   logic [7:0]    gate_gen_r;
   logic [7:0]    gate_a_r;
   logic [7:0]    gate_c_r;
   logic [7:0]    scratch_r;
   slp_state_t    state_r;
   slp_state_t    state_nxt;
   slp_mode_t     mode_r;
   logic [15:0]   cnt_r;
   logic          wake_ok;
   logic          mode_valid;
   logic [2:0]    sel_mode;
   logic [SLP_NPER-1:0] gates;
   logic          wb_req;
   logic [7:0]    wdat;
   logic [7:0]    frz_rdata;
   logic [4:0]    frz_addr_r;
   logic          osc_stopped;

   // reset release through two flip-flops
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // wake inputs are asynchronous to the core clock
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_s1_r <= '0;
         wake_s2_r <= '0;
      end
      else
      begin
         wake_s1_r <= wake_src;
         wake_s2_r <= wake_s1_r;
      end
   end

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wdat   = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;

   // register writes; reset clears everything, full reset from vector
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r     <= SLP_CTRL_RST;
         wcfg_r     <= 8'h00;
         gate_gen_r <= 8'h00;
         gate_a_r   <= 8'h00;
         gate_c_r   <= 8'h00;
         scratch_r  <= 8'h00;
      end
      else if (wb_req && wb_we_i && wb_sel_i[0])
      begin
         case (wb_adr_i)
            SLP_ADR_CTRL:     ctrl_r     <= wdat & SLP_CTRL_MASK;
            SLP_ADR_WAKECFG:  wcfg_r     <= wdat & SLP_WCFG_MASK;
            SLP_ADR_GATE_GEN: gate_gen_r <= wdat & SLP_GATE_GEN_PRESENT;
            SLP_ADR_GATE_A:   gate_a_r   <= wdat & SLP_GATE_A_PRESENT;
            SLP_ADR_GATE_C:   gate_c_r   <= wdat & SLP_GATE_C_PRESENT;
            SLP_ADR_SCRATCH:  scratch_r  <= wdat;
            default:          scratch_r  <= scratch_r;
         endcase
      end
   end

   // bus answer: one cycle after request, unmapped reads zero
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               SLP_ADR_CTRL:     wb_dat_o <= {24'h000000, ctrl_r};
               SLP_ADR_WAKECFG:  wb_dat_o <= {24'h000000, wcfg_r};
               SLP_ADR_GATE_GEN: wb_dat_o <= {24'h000000, gate_gen_r};
               SLP_ADR_GATE_A:   wb_dat_o <= {24'h000000, gate_a_r};
               SLP_ADR_GATE_C:   wb_dat_o <= {24'h000000, gate_c_r};
               SLP_ADR_STATUS:   wb_dat_o <= {24'h000000, 2'b00, mode_r, state_r};
               SLP_ADR_FROZEN:   wb_dat_o <= {24'h000000, frz_rdata};
               SLP_ADR_SCRATCH:  wb_dat_o <= {24'h000000, scratch_r};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // mode decode with reserved codes rejected
   assign sel_mode = ctrl_r[SLP_CTRL_MODE_LSB +: 3];
   always_comb
   begin
      case (sel_mode)
         SLP_MODE_IDLE, SLP_MODE_DEEP, SLP_MODE_TIMER,
         SLP_MODE_OSC, SLP_MODE_OSC_TIMER: mode_valid = 1'b1;
         default:                          mode_valid = 1'b0;
      endcase
   end

   // wake source qualification per mode
   always_comb
   begin
      case (mode_r)
         SLP_MODE_IDLE:
            wake_ok = wake_s2_r.any_irq;
         SLP_MODE_DEEP:
            wake_ok = wake_s2_r.port_async | wake_s2_r.twi_match;
         SLP_MODE_TIMER:
            wake_ok = wake_s2_r.port_async | wake_s2_r.twi_match
                    | (wake_s2_r.rtc_irq & wcfg_r[SLP_WCFG_RTC_BIT])
                    | (wake_s2_r.uart_irq & wcfg_r[SLP_WCFG_SFD_BIT]
                       & wcfg_r[SLP_WCFG_LPM_BIT]);
         SLP_MODE_OSC:
            wake_ok = wake_s2_r.port_async | wake_s2_r.twi_match
                    | (wake_s2_r.uart_irq & wcfg_r[SLP_WCFG_SFD_BIT]);
         SLP_MODE_OSC_TIMER:
            wake_ok = wake_s2_r.port_async | wake_s2_r.twi_match
                    | (wake_s2_r.rtc_irq & wcfg_r[SLP_WCFG_RTC_BIT])
                    | (wake_s2_r.uart_irq & wcfg_r[SLP_WCFG_SFD_BIT]);
         default:
            wake_ok = 1'b0;
      endcase
   end

   assign osc_stopped = (mode_r == SLP_MODE_DEEP) || (mode_r == SLP_MODE_TIMER);

   // sleep sequencer
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         SLP_ST_ACTIVE:
            if (sleep_instr && ctrl_r[SLP_CTRL_ARM_BIT] && mode_valid)
               state_nxt = SLP_ST_SLEEP;
         SLP_ST_SLEEP:
            if (wake_ok)
               state_nxt = osc_stopped ? SLP_ST_OSC : SLP_ST_HALT;
         SLP_ST_OSC:
            if (cnt_r == 16'(OSC_START_CYC - 1))
               state_nxt = SLP_ST_HALT;
         SLP_ST_HALT:
            if (cnt_r == 16'(SLP_HALT_CYC - 1))
               state_nxt = SLP_ST_RESUME;
         SLP_ST_RESUME:
            if (wake_serviced)
               state_nxt = SLP_ST_ACTIVE;
         default:
            state_nxt = SLP_ST_ACTIVE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= SLP_ST_ACTIVE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // mode latched at entry so a later write cannot alter a sleep
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r <= SLP_MODE_IDLE;
      end
      else if (state_r == SLP_ST_ACTIVE && state_nxt == SLP_ST_SLEEP)
      begin
         mode_r <= slp_mode_t'(sel_mode);
      end
   end

   // delay counter for oscillator start-up and halt
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 16'h0000;
      end
      else if (state_nxt != state_r)
      begin
         cnt_r <= 16'h0000;
      end
      else
      begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // cpu halt and resume flag
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cpu_halt  <= 1'b0;
         resume_ok <= 1'b0;
      end
      else
      begin
         cpu_halt  <= (state_nxt == SLP_ST_SLEEP) || (state_nxt == SLP_ST_OSC)
                   || (state_nxt == SLP_ST_HALT);
         resume_ok <= (state_nxt == SLP_ST_RESUME);
      end
   end

   // clock domain enables; gating never clears state so contents stay
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_en <= '1;
      end
      else if (state_nxt == SLP_ST_SLEEP || state_nxt == SLP_ST_OSC)
      begin
         clk_en.cpu <= 1'b0;
         clk_en.nvm <= 1'b0;
         clk_en.per <= (mode_r == SLP_MODE_IDLE) && (state_r == SLP_ST_SLEEP) ||
                       (sel_mode == SLP_MODE_IDLE) && (state_r == SLP_ST_ACTIVE);
         clk_en.rtc <= ((state_r == SLP_ST_ACTIVE) ? sel_mode : mode_r) != SLP_MODE_DEEP
                    && ((state_r == SLP_ST_ACTIVE) ? sel_mode : mode_r) != SLP_MODE_OSC;
         clk_en.rtcosc <= ((state_r == SLP_ST_ACTIVE) ? sel_mode : mode_r) != SLP_MODE_DEEP
                    && ((state_r == SLP_ST_ACTIVE) ? sel_mode : mode_r) != SLP_MODE_OSC;
         clk_en.sysosc <= (state_nxt == SLP_ST_OSC) ||
                    !(((state_r == SLP_ST_ACTIVE) ? sel_mode : mode_r) == SLP_MODE_DEEP ||
                      ((state_r == SLP_ST_ACTIVE) ? sel_mode : mode_r) == SLP_MODE_TIMER);
      end
      else
      begin
         clk_en <= '1;
      end
   end

   // per-peripheral gating, only meaningful with peripheral clock running
   assign gates = {gate_c_r, gate_a_r, gate_gen_r};
   genvar gi;
   generate
      for (gi = 0; gi < SLP_NPER; gi++)
      begin : g_per
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               per_clk_en[gi] <= 1'b1;
               per_io_en[gi]  <= 1'b1;
            end
            else
            begin
               per_clk_en[gi] <= !gates[gi] && (clk_en.per || state_nxt == SLP_ST_ACTIVE);
               per_io_en[gi]  <= !gates[gi];
            end
         end
      end
   endgenerate

   // record of peripherals frozen by gating, kept across sleep
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frz_addr_r <= 5'h00;
      end
      else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == SLP_ADR_FROZEN)
      begin
         frz_addr_r <= wdat[4:0];
      end
   end

   slp_gate_mem #(
      .WIDTH (8),
      .DEPTH (32),
      .AW    (5)
   ) u_frz (
      .clk   (core_clk),
      .rst_n (rst_n),
      .we    (1'b1),
      .waddr (frz_addr_r),
      .wdata ({7'h00, gates[frz_addr_r < 5'(SLP_NPER) ? frz_addr_r : 5'h00]}),
      .raddr (frz_addr_r),
      .rdata (frz_rdata)
   );
endmodule

// [hw/slp_gate_mem.sv]
// per-peripheral frozen state holding memory with registered read
`timescale 1ns/100ps
module slp_gate_mem
   import slp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW    = 5
)
(
   // clock
   input  wire logic             clk,
   input  wire logic             rst_n,
   // write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // read port
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end
endmodule

// [hw/slp_pkg.sv]
// sleep controller package: register map, field layout, modes, timing
package slp_pkg;
   // register byte addresses on the wishbone bus
   localparam logic [7:0] SLP_ADR_CTRL     = 8'h00;
   localparam logic [7:0] SLP_ADR_GATE_GEN = 8'h04;
   localparam logic [7:0] SLP_ADR_GATE_A   = 8'h08;
   localparam logic [7:0] SLP_ADR_GATE_C   = 8'h0C;
   localparam logic [7:0] SLP_ADR_STATUS   = 8'h10;
   localparam logic [7:0] SLP_ADR_WAKECFG  = 8'h14;
   localparam logic [7:0] SLP_ADR_FROZEN   = 8'h18;
   localparam logic [7:0] SLP_ADR_SCRATCH  = 8'h1C;
   // control register fields
   localparam int SLP_CTRL_ARM_BIT  = 0;
   localparam int SLP_CTRL_MODE_LSB = 1;
   localparam logic [7:0] SLP_CTRL_RST   = 8'h00;
   localparam logic [7:0] SLP_CTRL_MASK  = 8'h0F;
   // wake configuration fields
   localparam int SLP_WCFG_SFD_BIT  = 0;
   localparam int SLP_WCFG_LPM_BIT  = 1;
   localparam int SLP_WCFG_RTC_BIT  = 2;
   localparam logic [7:0] SLP_WCFG_MASK  = 8'h07;
   // peripherals present per gate register (absent bits read zero)
   localparam logic [7:0] SLP_GATE_GEN_PRESENT = 8'h87;
   localparam logic [7:0] SLP_GATE_A_PRESENT   = 8'h07;
   localparam logic [7:0] SLP_GATE_C_PRESENT   = 8'h7F;
   localparam int SLP_NPER = 24;
   localparam int SLP_GEN_RTC_BIT = 2;
   // timing
   localparam int SLP_CLK_HZ      = 50_000_000;
   localparam int SLP_HALT_CYC    = 4;
   localparam int SLP_OSC_START_US = 10;
   localparam int SLP_OSC_START_CYC = (SLP_OSC_START_US * (SLP_CLK_HZ / 1_000_000));
   // sleep mode select codes
   typedef enum logic [2:0]
   {
      SLP_MODE_IDLE      = 3'b000,
      SLP_MODE_DEEP      = 3'b010,
      SLP_MODE_TIMER     = 3'b011,
      SLP_MODE_OSC       = 3'b110,
      SLP_MODE_OSC_TIMER = 3'b111
   } slp_mode_t;
   // controller states
   typedef enum logic [2:0]
   {
      SLP_ST_ACTIVE = 3'b000,
      SLP_ST_SLEEP  = 3'b001,
      SLP_ST_OSC    = 3'b010,
      SLP_ST_HALT   = 3'b011,
      SLP_ST_RESUME = 3'b100
   } slp_state_t;
   // wake source bundle
   typedef struct packed
   {
      logic any_irq;
      logic port_async;
      logic twi_match;
      logic rtc_irq;
      logic uart_irq;
   } slp_wake_t;
   // clock enable bundle
   typedef struct packed
   {
      logic cpu;
      logic nvm;
      logic per;
      logic rtc;
      logic sysosc;
      logic rtcosc;
   } slp_clken_t;
endpackage

// [testbench/slp_cpu_model.sv]
// cpu and interrupt controller model on the far side
`timescale 1ns/100ps
module slp_cpu_model
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // bench commands
   input wire logic       go,
   input wire logic [3:0] svc_wait,
   // controller side
   input wire logic       resume_ok,
   output logic           sleep_instr,
   output logic           wake_serviced
);
   logic [3:0] cnt_r;
   // one cycle sleep instruction per command
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
         sleep_instr <= 1'b0;
      else
         sleep_instr <= go;
   // handlers run for a chosen time, then report done
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
      begin
         cnt_r <= 4'h0;
         wake_serviced <= 1'b0;
      end
      else
      begin
         wake_serviced <= 1'b0;
         if (resume_ok && !wake_serviced)
         begin
            cnt_r <= (cnt_r == svc_wait) ? 4'h0 : cnt_r + 4'h1;
            wake_serviced <= (cnt_r == svc_wait);
         end
      end
endmodule

// [testbench/slp_ctrl_chk.sv]
// assertion checker for the sleep controller ports
`timescale 1ns/100ps
module slp_ctrl_chk
   import slp_pkg::*;
#(
   parameter int OSC_START_CYC = SLP_OSC_START_CYC
)
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rstn,
   // bus
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic       wb_ack_o,
   // cpu side
   input wire logic       sleep_instr,
   input wire logic       wake_serviced,
   input wire logic       cpu_halt,
   input wire logic       resume_ok,
   input wire slp_wake_t  wake_src,
   input wire slp_clken_t clk_en
);
   logic [3:0] ctrl_r;
   logic [2:0] wcfg_r;
   logic       take;
   logic       ok;
   logic       valid;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   assign valid = ctrl_r[0] && (ctrl_r[3:1] inside {3'h0, 3'h2, 3'h3, 3'h6, 3'h7});
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
         ctrl_r <= 4'h0;
      else if (take && wb_adr_i == SLP_ADR_CTRL)
         ctrl_r <= wb_dat_i[3:0];
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
         wcfg_r <= 3'h0;
      else if (take && wb_adr_i == SLP_ADR_WAKECFG)
         wcfg_r <= wb_dat_i[2:0];
   // wake sources accepted by the selected mode
   function automatic logic wake_ok(input logic [2:0] m, input logic [2:0] c,
                                    input logic [4:0] w);
      logic base;
      base = w[3] | w[2];
      case (m)
         SLP_MODE_IDLE:  wake_ok = |w;
         SLP_MODE_DEEP:  wake_ok = base;
         SLP_MODE_TIMER: wake_ok = base | (w[1] & c[2]) | (w[0] & c[0] & c[1]);
         SLP_MODE_OSC:   wake_ok = base | (w[0] & c[0]);
         default:        wake_ok = base | (w[1] & c[2]) | (w[0] & c[0]);
      endcase
   endfunction
   assign ok = wake_ok(ctrl_r[3:1], wcfg_r, wake_src);
   // cycles since an accepted wake source was last seen, saturating
   localparam int QUIET_CYC = OSC_START_CYC + SLP_HALT_CYC + 4;
   logic [15:0] quiet_r;
   always_ff @(posedge core_clk or negedge rstn)
      if (!rstn)
         quiet_r <= 16'h0000;
      else if (ok)
         quiet_r <= 16'h0000;
      else if (quiet_r != 16'hFFFF)
         quiet_r <= quiet_r + 16'h0001;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_req;
      sleep_instr && !cpu_halt && !resume_ok;
   endsequence
   sequence s_wake;
      $rose(ok) && cpu_halt;
   endsequence
   a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a one cycle answer");
   a_active_clocks: assert property (!cpu_halt && !resume_ok |-> clk_en.cpu && clk_en.per)
      else $error("active mode without cpu or peripheral clock");
   a_sleep_entry: assert property (s_req ##0 valid |=> cpu_halt)
      else $error("armed sleep request not taken");
   a_no_entry: assert property (s_req ##0 !valid |=> (!cpu_halt)[*3])
      else $error("sleep taken while unarmed or reserved");
   a_wake_gated: assert property (cpu_halt && quiet_r > 16'(QUIET_CYC) |=> cpu_halt)
      else $error("wake from a source the mode refuses");
   a_halt_min: assert property (s_wake |-> cpu_halt[*6])
      else $error("cpu released before halt cycles");
   a_osc_start: assert property (s_wake ##0 (ctrl_r[3:1] inside {3'h2, 3'h3}) |-> ##5 cpu_halt[*8])
      else $error("oscillator start time missing");
   a_wake_bound: assert property (s_wake |-> ##[6:40] !cpu_halt)
      else $error("accepted wake did not end sleep");
   a_resume_start: assert property ($fell(cpu_halt) |-> resume_ok)
      else $error("resume flag missing after wake");
   a_resume_hold: assert property (resume_ok && !wake_serviced |=> resume_ok)
      else $error("resume flag dropped before service");
endmodule
bind slp_ctrl slp_ctrl_chk #(.OSC_START_CYC(OSC_START_CYC)) chk (
   .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_ack_o(wb_ack_o), .sleep_instr(sleep_instr), .wake_serviced(wake_serviced),
   .cpu_halt(cpu_halt), .resume_ok(resume_ok), .wake_src(wake_src), .clk_en(clk_en));

// [testbench/testbench.sv]
// self-checking bench for the sleep controller
`timescale 1ns/100ps
module testbench;
   import slp_pkg::*;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        go = 1'b0;
   logic [3:0]  svc = 4'h2;
   slp_wake_t   wake_src = 5'h00;
   logic        sleep_instr, wake_serviced, cpu_halt, resume_ok;
   slp_clken_t  clk_en;
   logic [23:0] per_clk_en, per_io_en;
   logic [31:0] rdq[$];
   logic [31:0] r;
   integer      seed = 32'h0B7A0497;
   integer      mismatches = 0;
   integer      num_checks = 0;
   always #10 core_clk = ~core_clk;
   slp_ctrl #(.OSC_START_CYC(8)) dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
      .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sleep_instr(sleep_instr), .wake_serviced(wake_serviced), .cpu_halt(cpu_halt),
      .resume_ok(resume_ok), .wake_src(wake_src), .clk_en(clk_en),
      .per_clk_en(per_clk_en), .per_io_en(per_io_en));
   slp_cpu_model cpu (.core_clk(core_clk), .rstn(rstn), .go(go), .svc_wait(svc),
      .resume_ok(resume_ok), .sleep_instr(sleep_instr), .wake_serviced(wake_serviced));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic fail_out;
      mismatches++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      results;
   endtask
   task automatic tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                     input logic [3:0] sel, input logic [31:0] exp);
      integer n;
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= {24'h0, d};
      wb_sel <= sel;
      if (!we)
         rdq.push_back(exp);
      for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
         @(posedge core_clk);
      if (n == 50)
         fail_out;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      wb(1'b1, adr, d, 4'hF, 32'h0);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 8'h00, 4'hF, exp);
   endtask
   task automatic go_sleep;
      @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      tick(3);
   endtask
   task automatic sleep_case(input logic [2:0] m, input logic [4:0] bad, input logic [4:0] good,
                             input logic [5:0] clk, input logic deep);
      integer n;
      r = $random(seed);
      svc <= {1'b0, r[2:0]} + 4'h2;
      wr(SLP_ADR_CTRL, {4'h0, m, 1'b1});
      go_sleep;
      check(cpu_halt, 1, "sleep entry");
      check(clk_en, clk, "sleep clocks");
      check(per_clk_en, clk[3] ? 24'hFFFFFF : 24'h000000, "sleep gates");
      rd(SLP_ADR_STATUS, {26'h0, m, SLP_ST_SLEEP});
      wake_src <= bad;
      tick(20);
      check(cpu_halt, 1, "refused wake");
      wake_src <= bad | good;
      for (n = 0; n < 100 && cpu_halt !== 1'b0; n++)
         @(posedge core_clk);
      if (n == 100)
         fail_out;
      check(n >= (deep ? 14 : 6), 1, "wake delay");
      check(deep || n < 14, 1, "short wake");
      check(resume_ok, 1, "resume");
      for (n = 0; n < 50 && resume_ok !== 1'b0; n++)
         @(posedge core_clk);
      if (n == 50)
         fail_out;
      wake_src <= 5'h00;
      wr(SLP_ADR_CTRL, 8'h00);
   endtask
   // read data against the oldest note
   always @(posedge core_clk)
      if (wb_ack_o === 1'b1 && !wb_we)
         check(wb_dat_o, rdq.pop_front(), "read data");
   initial
   begin
      tick(20000);
      fail_out;
   end
   initial
   begin
      logic [7:0] gadr[3];
      logic [7:0] gmask[3];
      logic [2:0] resv[3];
      logic [7:0] keep;
      gadr = '{SLP_ADR_GATE_GEN, SLP_ADR_GATE_A, SLP_ADR_GATE_C};
      gmask = '{SLP_GATE_GEN_PRESENT, SLP_GATE_A_PRESENT, SLP_GATE_C_PRESENT};
      resv = '{3'h1, 3'h4, 3'h5};
      tick(20);
      rstn <= 1'b1;
      tick(4);
      rd(SLP_ADR_CTRL, 32'h0);
      wr(SLP_ADR_CTRL, 8'hFF);
      rd(SLP_ADR_CTRL, 32'h0F);
      wr(SLP_ADR_CTRL, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         wr(gadr[i], 8'hFF);
         rd(gadr[i], {24'h0, gmask[i]});
      end
      tick(2);
      check($countones(~per_clk_en), 14, "gated clocks");
      check($countones(~per_io_en), 14, "gated io");
      wr(SLP_ADR_FROZEN, 8'h07);
      rd(SLP_ADR_FROZEN, 32'h1);
      wr(SLP_ADR_FROZEN, 8'h03);
      rd(SLP_ADR_FROZEN, 32'h0);
      for (int i = 0; i < 3; i++)
         wr(gadr[i], 8'h00);
      tick(2);
      check(per_clk_en, 24'hFFFFFF, "clocks back");
      check(per_io_en, 24'hFFFFFF, "io back");
      rd(8'h20, 32'h0);
      repeat (3)
      begin
         r = $random(seed);
         wr(SLP_ADR_SCRATCH, r[7:0]);
         rd(SLP_ADR_SCRATCH, {24'h0, r[7:0]});
      end
      keep = r[7:0];
      wb(1'b1, SLP_ADR_SCRATCH, ~r[7:0], 4'h0, 32'h0);
      rd(SLP_ADR_SCRATCH, {24'h0, r[7:0]});
      for (int i = 0; i < 3; i++)
      begin
         wr(SLP_ADR_CTRL, {4'h0, resv[i], 1'b1});
         go_sleep;
         check(cpu_halt, 0, "reserved mode");
      end
      wr(SLP_ADR_CTRL, {4'h0, SLP_MODE_DEEP, 1'b0});
      go_sleep;
      check(cpu_halt, 0, "unarmed sleep");
      wr(SLP_ADR_WAKECFG, 8'h05);
      sleep_case(SLP_MODE_IDLE, 5'h00, 5'h10, 6'h0F, 1'b0);
      sleep_case(SLP_MODE_DEEP, 5'h13, 5'h04, 6'h00, 1'b1);
      sleep_case(SLP_MODE_TIMER, 5'h11, 5'h02, 6'h05, 1'b1);
      sleep_case(SLP_MODE_OSC, 5'h12, 5'h01, 6'h02, 1'b0);
      sleep_case(SLP_MODE_OSC_TIMER, 5'h10, 5'h08, 6'h07, 1'b0);
      wr(SLP_ADR_WAKECFG, 8'h07);
      sleep_case(SLP_MODE_TIMER, 5'h10, 5'h01, 6'h05, 1'b1);
      rd(SLP_ADR_SCRATCH, {24'h0, keep});
      wr(SLP_ADR_CTRL, {4'h0, SLP_MODE_DEEP, 1'b1});
      go_sleep;
      rstn <= 1'b0;
      tick(3);
      rstn <= 1'b1;
      tick(4);
      check(cpu_halt, 0, "reset wake");
      rd(SLP_ADR_CTRL, 32'h0);
      tick(5);
      results;
   end
endmodule
